/* src/ras_pkg.sv */
package ras_pkg;
   // geometry
   localparam int unsigned RAS_DEPTH   = 8;
   localparam int unsigned RAS_PTR_W   = 3;
   localparam int unsigned RAS_PC_W    = 11;
   localparam int unsigned RAS_PCH_W   = 3;
   localparam int unsigned RAS_PCL_W   = 8;

   // register indexes; byte address is four times the index
   localparam logic [7:0] RAS_IDX_SP         = 8'hdf;
   localparam logic [7:0] RAS_IDX_ENTRY_BASE = 8'hf0;
   localparam logic [7:0] RAS_IDX_ENTRY_LAST = 8'hff;

   // pointer register fields
   localparam int unsigned RAS_SP_GIE_BIT = 7;
   localparam int unsigned RAS_SP_PTR_LSB = 0;
   localparam int unsigned RAS_SP_PTR_MSB = 2;

   // entry register fields
   localparam int unsigned RAS_ENT_HI_MSB = 2;

   // reset values
   localparam logic [2:0]  RAS_PTR_RST  = 3'h7;
   localparam logic        RAS_GIE_RST  = 1'b0;
   localparam logic [10:0] RAS_PC_RST   = 11'h000;
   localparam logic [31:0] RAS_RD_ZERO  = 32'h0000_0000;

   typedef enum logic [2:0] {
      RAS_OP_IDLE = 3'b001,
      RAS_OP_PUSH = 3'b010,
      RAS_OP_POP  = 3'b100
   } ras_op_t;
endpackage

/* src/ras_pointer.sv */
`timescale 1ns/100ps
`default_nettype none
module ras_pointer
   import ras_pkg::*;
(
   input  wire logic [2:0] i_ptr,
   input  wire ras_op_t    i_op,
   output logic [2:0]      o_ptr_next,
   output logic [2:0]      o_entry
);
   always_comb begin
      case (i_op)
         RAS_OP_PUSH: begin
            o_entry    = ~i_ptr;
            o_ptr_next = i_ptr - 3'h1;
         end
         RAS_OP_POP: begin
            o_ptr_next = i_ptr + 3'h1;
            o_entry    = ~(i_ptr + 3'h1);
         end
         default: begin
            o_ptr_next = i_ptr;
            o_entry    = ~i_ptr;
         end
      endcase
   end
endmodule
`default_nettype wire

/* src/ras_stack.sv */
// Behaviour
// - eight levels save and restore the pc
// - three-bit pointer in bits two to zero
// - entries eleven bits, high/low bytes, reset zero
// - push decrements pointer, pop increments it
// - pointer tracks next free entry; push writes that entry
// - pc saved on call and interrupt entry
// - last in, first out ordering
// - saved value is the opcode's pc
// - empty is 111; push writes entry 7-p
// - both return kinds pop and increment pointer
// - pop loads saved value into the pc
// - pointer and entries mapped in system area
// - bit seven is global interrupt enable
// - saved pc is eleven bits, 3+8
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ras_stack
   import ras_pkg::*;
#(
   parameter int unsigned DEPTH  = RAS_DEPTH,
   parameter int unsigned ADR_W  = 10
) (
   input  wire logic                i_mclk,
   input  wire logic                i_nrst,
   input  wire logic                i_ce,
   // core sequencer side
   input  wire logic                i_call_push,
   input  wire logic                i_irq_push,
   input  wire logic [RAS_PC_W-1:0] i_push_pc,
   input  wire logic                i_return_from_subroutine,
   input  wire logic                i_return_from_interrupt,
   output logic [RAS_PC_W-1:0]      o_ret_pc,
   output logic                     o_ret_pc_valid,
   output logic [RAS_PTR_W-1:0]     o_stack_ptr,
   output logic                     o_global_irq_enable,
   // wishbone classic slave
   input  wire logic                i_wb_cyc,
   input  wire logic                i_wb_stb,
   input  wire logic                i_wb_we,
   input  wire logic [ADR_W-1:0]    i_wb_adr,
   input  wire logic [3:0]          i_wb_sel,
   input  wire logic [31:0]         i_wb_dat,
   output logic [31:0]              o_wb_dat,
   output logic                     o_wb_ack
);
   // elaboration-time refusal of geometries the pointer logic or the register map cannot serve
   generate
      if (DEPTH != RAS_DEPTH) begin : g_bad_depth
         $error("ras_stack: DEPTH must match the three-bit pointer");
      end
      if (ADR_W < 10) begin : g_bad_adr
         $error("ras_stack: ADR_W too small for the register map");
      end
   endgenerate

   logic [RAS_PC_W-1:0]  stack_mem [DEPTH];
   logic [RAS_PTR_W-1:0] stack_pointer_reg;
   logic                 global_irq_enable_reg;
   logic [RAS_PC_W-1:0]  ret_pc_reg;
   logic                 ret_valid_reg;
   logic [31:0]          rd_reg;

   ras_op_t              op;
   logic [RAS_PTR_W-1:0] ptr_next;
   logic [RAS_PTR_W-1:0] op_entry;
   logic                 load;
   logic                 wr_en;
   logic [7:0]           idx;
   logic                 hit_sp;
   logic                 hit_ent;
   logic [RAS_PTR_W-1:0] sw_entry;
   logic                 sw_high;
   logic [31:0]          rd_next;

   // push has priority if the sequencer ever raises both
   always_comb begin
      if (i_call_push | i_irq_push) begin
         op = RAS_OP_PUSH;
      end else if (i_return_from_subroutine | i_return_from_interrupt) begin
         op = RAS_OP_POP;
      end else begin
         op = RAS_OP_IDLE;
      end
   end

   ras_pointer u_ptr (
      .i_ptr      (stack_pointer_reg),
      .i_op       (op),
      .o_ptr_next (ptr_next),
      .o_entry    (op_entry)
   );

   ras_wb_ack u_ack (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_ce   (i_ce),
      .i_cyc  (i_wb_cyc),
      .i_stb  (i_wb_stb),
      .o_ack  (o_wb_ack),
      .o_load (load)
   );

   // register decode: index is the word address
   assign idx      = i_wb_adr[9:2];
   assign hit_sp   = (idx == RAS_IDX_SP);
   assign hit_ent  = (idx >= RAS_IDX_ENTRY_BASE) && (idx <= RAS_IDX_ENTRY_LAST);
   assign sw_entry = idx[3:1];
   assign sw_high  = idx[0];
   // write lands on the edge where the master sees ack
   assign wr_en    = i_ce & o_wb_ack & i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0];

   // pointer: hardware op beats a software write in the same cycle
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         stack_pointer_reg <= RAS_PTR_RST;
      end else if (i_ce) begin
         if (op != RAS_OP_IDLE) begin
            stack_pointer_reg <= ptr_next;
         end else if (wr_en && hit_sp) begin
            stack_pointer_reg <= i_wb_dat[RAS_SP_PTR_MSB:RAS_SP_PTR_LSB];
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         global_irq_enable_reg <= RAS_GIE_RST;
      end else if (i_ce && wr_en && hit_sp) begin
         global_irq_enable_reg <= i_wb_dat[RAS_SP_GIE_BIT];
      end
   end

   // entries: a push beats a software write to the same entry
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_ent
         always_ff @(posedge i_mclk or negedge i_nrst) begin
            if (!i_nrst) begin
               stack_mem[g] <= RAS_PC_RST;
            end else if (i_ce) begin
               if (op == RAS_OP_PUSH && op_entry == RAS_PTR_W'(g)) begin
                  stack_mem[g] <= i_push_pc;
               end else if (wr_en && hit_ent && sw_entry == RAS_PTR_W'(g)) begin
                  if (sw_high) begin
                     stack_mem[g][RAS_PC_W-1:RAS_PCL_W] <=
                        i_wb_dat[RAS_ENT_HI_MSB:0];
                  end else begin
                     stack_mem[g][RAS_PCL_W-1:0] <= i_wb_dat[RAS_PCL_W-1:0];
                  end
               end
            end
         end
      end
   endgenerate

   // pop hands the saved pc back to the sequencer
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ret_pc_reg    <= RAS_PC_RST;
         ret_valid_reg <= 1'b0;
      end else if (i_ce) begin
         ret_valid_reg <= (op == RAS_OP_POP);
         if (op == RAS_OP_POP) begin
            ret_pc_reg <= stack_mem[op_entry];
         end
      end
   end

   always_comb begin
      rd_next = RAS_RD_ZERO;
      if (hit_sp) begin
         rd_next[RAS_SP_GIE_BIT] = global_irq_enable_reg;
         rd_next[RAS_SP_PTR_MSB:RAS_SP_PTR_LSB] = stack_pointer_reg;
      end else if (hit_ent) begin
         if (sw_high) begin
            rd_next[RAS_ENT_HI_MSB:0] = stack_mem[sw_entry][RAS_PC_W-1:RAS_PCL_W];
         end else begin
            rd_next[RAS_PCL_W-1:0] = stack_mem[sw_entry][RAS_PCL_W-1:0];
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         rd_reg <= RAS_RD_ZERO;
      end else if (load) begin
         rd_reg <= rd_next;
      end
   end

   assign o_wb_dat            = rd_reg;
   assign o_ret_pc            = ret_pc_reg;
   assign o_ret_pc_valid      = ret_valid_reg;
   assign o_stack_ptr         = stack_pointer_reg;
   assign o_global_irq_enable = global_irq_enable_reg;
endmodule
`default_nettype wire

/* src/ras_wb_ack.sv */
`timescale 1ns/100ps
`default_nettype none
module ras_wb_ack (
   input  wire logic i_mclk,
   input  wire logic i_nrst,
   input  wire logic i_ce,
   input  wire logic i_cyc,
   input  wire logic i_stb,
   output logic      o_ack,
   output logic      o_load
);
   // one wait state; ack drops the cycle after it was given
   assign o_load = i_ce & i_cyc & i_stb & ~o_ack;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ack <= 1'b0;
      end else if (i_ce) begin
         o_ack <= i_cyc & i_stb & ~o_ack;
      end
   end
endmodule
`default_nettype wire

/* tb/ras_seq_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ras_seq_model (
   input  wire logic   i_mclk,
   output logic        o_call_push,
   output logic        o_irq_push,
   output logic        o_ret_sub,
   output logic        o_ret_irq,
   output logic [10:0] o_pc
);
   initial begin
      {o_call_push, o_irq_push, o_ret_sub, o_ret_irq} = 4'h0;
      o_pc = 11'h000;
   end
   // k = {call, irq entry, return, irq return}; each non-push op inverts the pc
   task automatic op(input logic [3:0] k, input logic [10:0] pc);
      @(posedge i_mclk);
      {o_call_push, o_irq_push, o_ret_sub, o_ret_irq} <= k;
      o_pc <= (k[3] | k[2]) ? pc : ~o_pc;
   endtask
endmodule
`default_nettype wire

/* tb/ras_stack_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module ras_stack_monitor (
   input wire logic        i_mclk,
   input wire logic        i_nrst,
   input wire logic        i_ce,
   input wire logic        i_call_push,
   input wire logic        i_irq_push,
   input wire logic [10:0] i_push_pc,
   input wire logic        i_return_from_subroutine,
   input wire logic        i_return_from_interrupt,
   input wire logic [10:0] o_ret_pc,
   input wire logic        o_ret_pc_valid,
   input wire logic [2:0]  o_stack_ptr,
   input wire logic        o_global_irq_enable,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [9:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic        o_wb_ack
);
   wire psh = i_ce & (i_call_push | i_irq_push);
   wire pop = i_ce & (i_return_from_subroutine | i_return_from_interrupt) & !psh;
   wire spw = i_ce & i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0]
              & (i_wb_adr[9:2] == 8'hdf);
   wire spo = spw & !psh & !pop;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   sequence push_s; psh; endsequence
   sequence pop_s; pop; endsequence
   push_dec_a: assert property (push_s |=> o_stack_ptr == $past(o_stack_ptr) - 3'h1)
      else $error("ptr not decremented");
   pop_inc_a: assert property (pop_s |=> o_stack_ptr == $past(o_stack_ptr) + 3'h1)
      else $error("ptr not incremented");
   ret_valid_a: assert property (pop_s |=> o_ret_pc_valid)
      else $error("no return valid");
   valid_pulse_a: assert property (i_ce && !pop |=> !o_ret_pc_valid)
      else $error("stray return valid");
   lifo_order_a: assert property (push_s ##1 pop_s |=> o_ret_pc == $past(i_push_pc, 2))
      else $error("pop not last push");
   ptr_write_a: assert property (spo |=> o_stack_ptr == $past(i_wb_dat[2:0]))
      else $error("ptr write lost");
   gie_write_a: assert property (spw |=> o_global_irq_enable == $past(i_wb_dat[7]))
      else $error("enable write lost");
   ack_delay_a: assert property (i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack late");
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        i_mclk = 1'b0;
   logic        i_nrst = 1'b0;
   logic        i_ce = 1'b1;
   logic        i_wb_cyc = 1'b0;
   logic        i_wb_stb = 1'b0;
   logic        i_wb_we = 1'b0;
   logic [9:0]  i_wb_adr = 10'h000;
   logic [3:0]  i_wb_sel = 4'h1;
   logic [31:0] i_wb_dat = 32'h0000_0000;
   logic [31:0] o_wb_dat;
   logic [10:0] i_push_pc, o_ret_pc;
   logic [2:0]  o_stack_ptr;
   logic        i_call_push, i_irq_push, i_return_from_subroutine, i_return_from_interrupt;
   logic        o_ret_pc_valid, o_global_irq_enable, o_wb_ack;
   int          fails = 0;
   int          n_checks = 0;
   always #50 i_mclk = ~i_mclk;
   ras_stack dut_u (.*);
   ras_seq_model seq_u (.i_mclk(i_mclk), .o_call_push(i_call_push), .o_irq_push(i_irq_push),
      .o_ret_sub(i_return_from_subroutine), .o_ret_irq(i_return_from_interrupt),
      .o_pc(i_push_pc));
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
      int n;
      @(posedge i_mclk);
      {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'b11, w};
      i_wb_adr <= {idx, 2'b00};
      i_wb_dat <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      q = o_wb_dat[7:0];
      {i_wb_cyc, i_wb_stb} <= 2'b00;
      if (n >= 20) begin
         fails++;
         summarize();
      end
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
      logic [7:0] q;
      wb(1'b0, idx, 8'h00, q);
      chk(nm, {3'h0, e}, {3'h0, q});
   endtask
   task automatic reset_vals();
      rd(8'hdf, 8'h07, "ptr reg");
      rd(8'hf1, 8'h00, "entry0 hi");
      rd(8'h10, 8'h00, "unmapped");
   endtask
   task automatic fill_pop();
      for (int i = 0; i < 9; i++) begin
         seq_u.op(i[0] ? 4'h4 : 4'h8, 11'h5a0 + 11'(i));
         if (i == 7) begin
            seq_u.op(4'h0, 11'h000);
            @(negedge i_mclk);
            chk("ptr", 11'h7, {8'h00, o_stack_ptr});
            rd(8'hfe, 8'ha7, "entry7 lo");
            rd(8'hff, 8'h05, "entry7 hi");
         end
      end
      seq_u.op(4'h0, 11'h000);
      @(negedge i_mclk);
      chk("ptr", 11'h6, {8'h00, o_stack_ptr});
      rd(8'hf0, 8'ha8, "entry0 lo");
      for (int k = 0; k < 8; k++) begin
         seq_u.op(k[0] ? 4'h1 : 4'h2, 11'h000);
         seq_u.op(4'h0, 11'h000);
         @(negedge i_mclk);
         chk("ret pc", 11'h5a8 - 11'(k), o_ret_pc);
         chk("ret valid", 11'h1, {10'h000, o_ret_pc_valid});
         chk("ptr", {8'h00, 3'(7 + k)}, {8'h00, o_stack_ptr});
      end
   endtask
   task automatic sw_ptr();
      logic [7:0] q;
      wb(1'b1, 8'hdf, 8'hff, q);
      rd(8'hdf, 8'h87, "ptr reg");
      chk("irq enable", 11'h1, {10'h000, o_global_irq_enable});
      wb(1'b1, 8'hf4, 8'h3c, q);
      wb(1'b1, 8'hf5, 8'h02, q);
      wb(1'b1, 8'hdf, 8'h04, q);
      seq_u.op(4'h2, 11'h000);
      seq_u.op(4'h8, 11'h1e5);
      seq_u.op(4'h1, 11'h000);
      @(negedge i_mclk);
      chk("ret pc", 11'h23c, o_ret_pc);
      seq_u.op(4'h0, 11'h000);
      @(negedge i_mclk);
      chk("ret pc", 11'h1e5, o_ret_pc);
      wb(1'b1, 8'hdf, 8'h7f, q);
      rd(8'hdf, 8'h07, "ptr reg");
      // a push offered while the clock enable is low must leave all state alone
      @(posedge i_mclk);
      i_ce <= 1'b0;
      seq_u.op(4'h8, 11'h111);
      seq_u.op(4'h0, 11'h000);
      @(negedge i_mclk);
      chk("ptr frozen", 11'h7, {8'h00, o_stack_ptr});
      @(posedge i_mclk);
      i_ce <= 1'b1;
      rd(8'hf0, 8'ha8, "entry0 frozen");
   endtask
   initial begin
      repeat (16) @(posedge i_mclk);
      i_nrst <= 1'b1;
      reset_vals();
      fill_pop();
      sw_ptr();
      summarize();
   end
endmodule
bind ras_stack ras_stack_monitor mon_u (.*);
`default_nettype wire
